// ==== rtl/debug_auth_consts.svh ====
// Offsets, field positions, reset values and widths for the debug gate
`ifndef DEBUG_AUTH_CONSTS_SVH
`define DEBUG_AUTH_CONSTS_SVH

// Debug register numbers; the byte address is the number times four
`define REGNUM_INSTR_XFER   10'd33
`define REGNUM_STATUS_CTRL  10'd34
`define REGNUM_RUN_CTRL     10'd36
`define REGNUM_AUTH_STATUS  10'd1006

// Bus geometry
`define APB_ADDR_W          12
`define APB_DATA_W          32

// Status and control register fields
`define SC_HALTED_BIT       0
`define SC_ENTRY_LSB        2
`define SC_ENTRY_MSB        5
`define SC_MODE_LSB         14
`define SC_MODE_MSB         15
`define SC_AUTH_LSB         16
`define SC_AUTH_MSB         17
`define SC_INSTR_DONE_BIT   24

// Entry method codes held in the entry field
`define ENTRY_RUN_CTRL      4'h0
`define ENTRY_EXT_REQUEST   4'h4

// Run control register bits (write only, self clearing)
`define RC_HALT_BIT         0
`define RC_RESTART_BIT      1

// Authentication status register fields
`define AS_NS_INV_BIT       0
`define AS_NS_NONINV_BIT    2
`define AS_S_INV_BIT        4
`define AS_S_NONINV_BIT     6
`define AS_IMPL_MASK        32'h0000_00AA

// Reset values
`define MODE_RESET          2'h0
`define ENTRY_RESET         4'h0
`define OPCODE_RESET        32'h0000_0000

// Synchroniser depth for the authentication and halt pins
`define SYNC_STAGES         2

`endif

// ==== rtl/debug_auth_pkg.sv ====
// Types shared by the debug authentication gate
package debug_auth_pkg;

	// Execution state of the core as seen by the debug logic
	typedef enum logic {
		CORE_RUNNING,
		CORE_HALTED
	} core_state_e;

	// Debug mode select field value
	typedef logic [1:0] mode_sel_t;

	// Entry method field value
	typedef logic [3:0] entry_t;

	// Debug register number
	typedef logic [9:0] reg_num_t;

endpackage

// ==== rtl/pin_sync.sv ====
// Multi-bit two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns

module pin_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = 2
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Asynchronous pins and their synchronised copies
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_sync_out
);

	// Fewer than two stages would leave metastability exposed
	if (STAGES < 2 || WIDTH < 1) begin : g_bad_cfg
		$error("pin_sync: STAGES must be >= 2 and WIDTH >= 1");
	end

	logic [WIDTH-1:0] stage_r [STAGES];

	// Chain of flops; only the last stage is visible outside
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < STAGES; i++)
				stage_r[i] <= '0;
		end else begin
			stage_r[0] <= pin_in;
			for (int i = 1; i < STAGES; i++)
				stage_r[i] <= stage_r[i-1];
		end
	end

	assign pin_sync_out = stage_r[STAGES-1];

endmodule

// ==== rtl/instr_feed.sv ====
// Forced instruction issue and completion flag for debug state
`timescale 1ns/1ns
`include "debug_auth_consts.svh"

module instr_feed (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control from the register side
	input  wire logic        halted,
	input  wire logic        entering,
	input  wire logic        opcode_wr,
	input  wire logic [31:0] opcode_in,
	// Core execution handshake
	output logic             exec_valid,
	output logic      [31:0] exec_opcode,
	input  wire logic        exec_done,
	// Status
	output logic             instr_complete_flag
);

	logic        complete_r;
	logic        valid_r;
	logic [31:0] opcode_r;
	logic        accept;

	// Opcodes are only taken in debug state with the previous one retired
	assign accept = halted && complete_r && opcode_wr;          // [RULE_14]

	// Completion flag; core done wins over a same-cycle clear
	always_ff @(posedge clk) begin
		if (rst)
			complete_r <= 1'b1;
		else if (entering || (exec_done && valid_r))
			complete_r <= 1'b1;                                  // [RULE_13]
		else if (accept)
			complete_r <= 1'b0;
	end

	// Issue request held until the core reports completion
	always_ff @(posedge clk) begin
		if (rst)
			valid_r <= 1'b0;
		else if (exec_done && valid_r)
			valid_r <= 1'b0;
		else if (accept)
			valid_r <= 1'b1;                                     // [RULE_13]
	end

	// Opcode latch
	always_ff @(posedge clk) begin
		if (rst)
			opcode_r <= `OPCODE_RESET;
		else if (accept)
			opcode_r <= opcode_in;
	end

	assign exec_valid          = valid_r;
	assign exec_opcode         = opcode_r;
	assign instr_complete_flag = complete_r;

endmodule

// ==== rtl/debug_auth_gate.sv ====
// Debug authentication gate with APB debug registers and halt control
//
// What the document requires
// RULE_01 - Secure invasive needs secure-invasive and invasive enables
// RULE_02 - Nonsecure invasive follows the invasive enable alone
// RULE_03 - Nonsecure noninvasive when invasive or noninvasive enabled
// RULE_04 - Secure noninvasive needs a secure and a base enable
// RULE_05 - Invasive low forces mode select to zero
// RULE_06 - Invasive low makes halting debug events ignored
// RULE_07 - Status shows detected, synchronised values, not raw pins
// RULE_08 - Software follows the safe auth change sequence
// RULE_09 - No dependent operation before change sequence completes
// RULE_10 - Auth state readable in status and auth registers
// RULE_11 - Register number n sits at byte n times four
// RULE_12 - Debugger polls complete flag, writes opcode, polls again
// RULE_13 - Execute written opcodes; set complete flag when ready
// RULE_14 - Forced execution path is used only in debug state
// RULE_15 - Auth inputs are tied off or externally driven
// RULE_16 - External halt request enters debug, entry code recorded
// RULE_17 - Auth inputs synchronised before decoding, no glitches
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "debug_auth_consts.svh"

module debug_auth_gate #(
	// Synchroniser depth on every asynchronous pin
	parameter int SYNC_DEPTH = `SYNC_STAGES
) (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        rst,
	// Authentication pins, asynchronous
	input  wire logic                        secure_invasive_enable,
	input  wire logic                        invasive_enable,
	input  wire logic                        secure_noninvasive_enable,
	input  wire logic                        noninvasive_enable,
	// External halt request pin, asynchronous
	input  wire logic                        external_halt_request,
	// APB slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [`APB_ADDR_W-1:0]      paddr,
	input  wire logic [`APB_DATA_W-1:0]      pwdata,
	output logic      [`APB_DATA_W-1:0]      prdata,
	output logic                             pready,
	output logic                             pslverr,
	// Permission outputs
	output logic                             perm_secure_invasive,
	output logic                             perm_nonsecure_invasive,
	output logic                             perm_secure_noninvasive,
	output logic                             perm_nonsecure_noninvasive,
	// Core control
	output logic                             debug_state,
	output logic                             exec_valid,
	output logic      [31:0]                 exec_opcode,
	input  wire logic                        exec_done
);

	import debug_auth_pkg::*;

	// A single stage would pass metastable values to the decode
	if (SYNC_DEPTH < 2) begin : g_bad_depth
		$error("debug_auth_gate: SYNC_DEPTH must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation

	logic [4:0] pins_s;
	logic       spien_s;
	logic       inv_s;
	logic       spnien_s;
	logic       nien_s;
	logic       ext_req_s;

	// Every pin passes SYNC_DEPTH flops (two by default) before the decode sees it
	pin_sync #(
		.WIDTH  (5),
		.STAGES (SYNC_DEPTH)
	) u_pin_sync (
		.clk          (clk),
		.rst          (rst),
		.pin_in       ({external_halt_request, secure_invasive_enable,
		                invasive_enable, secure_noninvasive_enable,
		                noninvasive_enable}),
		.pin_sync_out (pins_s)                                  // [RULE_17]
	);

	assign ext_req_s = pins_s[4];
	assign spien_s   = pins_s[3];
	assign inv_s     = pins_s[2];
	assign spnien_s  = pins_s[1];
	assign nien_s    = pins_s[0];

	////////////////////////////////////////////////////////////////////////
	// Permission decode

	logic s_inv_r;
	logic ns_inv_r;
	logic s_nin_r;
	logic ns_nin_r;

	// Registered decode so outputs cannot glitch as pins settle;
	// the price is a pin change reaching the outputs three clocks late,
	// which software covers by polling the status before relying on it
	always_ff @(posedge clk) begin
		if (rst) begin
			s_inv_r  <= 1'b0;
			ns_inv_r <= 1'b0;
			s_nin_r  <= 1'b0;
			ns_nin_r <= 1'b0;
		end else begin
			s_inv_r  <= spien_s && inv_s;                        // [RULE_01]
			ns_inv_r <= inv_s;                                   // [RULE_02]
			ns_nin_r <= inv_s || nien_s;                         // [RULE_03]
			s_nin_r  <= (spien_s || spnien_s) &&
			            (inv_s || nien_s);                       // [RULE_04]
		end
	end

	assign perm_secure_invasive       = s_inv_r;
	assign perm_nonsecure_invasive    = ns_inv_r;
	assign perm_secure_noninvasive    = s_nin_r;
	assign perm_nonsecure_noninvasive = ns_nin_r;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	reg_num_t reg_num;
	logic     setup_ph;
	logic     access_ph;
	logic     hit_itr;
	logic     hit_sc;
	logic     hit_rc;
	logic     hit_as;
	logic     mapped;
	logic     wr_en;

	// Word index from the byte address, low two bits dropped
	assign reg_num   = paddr[`APB_ADDR_W-1:2];                   // [RULE_11]
	assign setup_ph  = psel && !penable;
	assign access_ph = psel && penable;
	assign hit_itr   = (reg_num == `REGNUM_INSTR_XFER);
	assign hit_sc    = (reg_num == `REGNUM_STATUS_CTRL);
	assign hit_rc    = (reg_num == `REGNUM_RUN_CTRL);
	assign hit_as    = (reg_num == `REGNUM_AUTH_STATUS);
	assign mapped    = hit_itr || hit_sc || hit_rc || hit_as;

	// No wait states; every access completes in its first access cycle
	// Writes to read-only places are dropped silently; writes to unmapped places are dropped with an error response
	assign pready = 1'b1;
	assign wr_en  = access_ph && pwrite && mapped;

	////////////////////////////////////////////////////////////////////////
	// Mode select and effective mode

	mode_sel_t mode_r;
	mode_sel_t mode_eff;

	// Software-written mode select held as written
	always_ff @(posedge clk) begin
		if (rst)
			mode_r <= `MODE_RESET;
		else if (wr_en && hit_sc)
			mode_r <= pwdata[`SC_MODE_MSB:`SC_MODE_LSB];
	end

	// With invasive debug off both monitor and halting modes are off
	assign mode_eff = ns_inv_r ? mode_r : `MODE_RESET;          // [RULE_05]

	////////////////////////////////////////////////////////////////////////
	// Halt and restart control

	core_state_e state_r;
	entry_t      entry_r;
	logic        rc_halt;
	logic        rc_restart;
	logic        halt_ok;
	logic        enter_ext;
	logic        enter_rc;
	logic        entering;

	assign rc_halt    = wr_en && hit_rc && pwdata[`RC_HALT_BIT];
	assign rc_restart = wr_en && hit_rc && pwdata[`RC_RESTART_BIT];

	// Halting events are dropped, not deferred, while invasive is off,
	// so a request that arrives too early must be raised again later
	assign halt_ok   = ns_inv_r && (state_r == CORE_RUNNING);   // [RULE_06]
	assign enter_ext = halt_ok && ext_req_s;                     // [RULE_16]
	assign enter_rc  = halt_ok && rc_halt && !ext_req_s;
	assign entering  = enter_ext || enter_rc;

	// Core state machine
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r <= CORE_RUNNING;
		end else begin
			case (state_r)
				CORE_RUNNING: begin
					if (entering)
						state_r <= CORE_HALTED;
				end
				CORE_HALTED: begin
					// Restart is ignored while an opcode is still in flight
					if (rc_restart && !exec_valid)
						state_r <= CORE_RUNNING;
				end
				default: state_r <= CORE_RUNNING;
			endcase
		end
	end

	// Entry method recorded at the moment of entry
	// External request wins over a run-control halt in the same cycle
	always_ff @(posedge clk) begin
		if (rst)
			entry_r <= `ENTRY_RESET;
		else if (enter_ext)
			entry_r <= `ENTRY_EXT_REQUEST;                       // [RULE_16]
		else if (enter_rc)
			entry_r <= `ENTRY_RUN_CTRL;
	end

	assign debug_state = (state_r == CORE_HALTED);

	////////////////////////////////////////////////////////////////////////
	// Forced instruction execution

	logic instr_done;

	// Opcode register writes feed the core only in debug state
	instr_feed u_instr_feed (
		.clk                 (clk),
		.rst                 (rst),
		.halted              (debug_state),                      // [RULE_14]
		.entering            (entering),
		.opcode_wr           (wr_en && hit_itr),                 // [RULE_13]
		.opcode_in           (pwdata),
		.exec_valid          (exec_valid),
		.exec_opcode         (exec_opcode),
		.exec_done           (exec_done),
		.instr_complete_flag (instr_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Read data

	logic [`APB_DATA_W-1:0] sc_word;
	logic [`APB_DATA_W-1:0] as_word;
	logic [`APB_DATA_W-1:0] rd_nxt;
	logic [`APB_DATA_W-1:0] prdata_r;
	logic                   err_r;

	// Status word built from detected values, never raw pins
	always_comb begin
		sc_word = '0;
		sc_word[`SC_HALTED_BIT]                 = debug_state;
		sc_word[`SC_ENTRY_MSB:`SC_ENTRY_LSB]    = entry_r;
		sc_word[`SC_MODE_MSB:`SC_MODE_LSB]      = mode_eff;      // [RULE_10]
		sc_word[`SC_AUTH_LSB]                   = ns_inv_r;      // [RULE_07]
		sc_word[`SC_AUTH_MSB]                   = ns_nin_r;      // [RULE_10]
		sc_word[`SC_INSTR_DONE_BIT]             = instr_done;    // [RULE_13]
	end

	// Authentication status: permission bits plus implemented marks
	always_comb begin
		as_word = `AS_IMPL_MASK;
		as_word[`AS_NS_INV_BIT]    = ns_inv_r;                   // [RULE_10]
		as_word[`AS_NS_NONINV_BIT] = ns_nin_r;
		as_word[`AS_S_INV_BIT]     = s_inv_r;
		as_word[`AS_S_NONINV_BIT]  = s_nin_r;                    // [RULE_07]
	end

	// Instruction transfer register is write only and reads zero
	// Run control is write only as well and also reads zero
	always_comb begin
		rd_nxt = '0;
		if (hit_sc)
			rd_nxt = sc_word;
		else if (hit_as)
			rd_nxt = as_word;
	end

	// Read data captured in setup so it is stable through access
	always_ff @(posedge clk) begin
		if (rst)
			prdata_r <= '0;
		else if (setup_ph && !pwrite)
			prdata_r <= rd_nxt;
	end

	// Error flag for unmapped addresses, valid through access
	always_ff @(posedge clk) begin
		if (rst)
			err_r <= 1'b0;
		else if (setup_ph)
			err_r <= !mapped;
	end

	// Error shown only in the access phase, as the bus expects
	assign prdata  = prdata_r;
	assign pslverr = access_ph && err_r;

endmodule

// ==== dv/debug_auth_gate_sva.sv ====
// Port-level assertions for the debug authentication gate
`timescale 1ns/1ns

module debug_auth_gate_sva (
	// Clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// Authentication and halt pins
	input wire logic        secure_invasive_enable,
	input wire logic        invasive_enable,
	input wire logic        secure_noninvasive_enable,
	input wire logic        noninvasive_enable,
	input wire logic        external_halt_request,
	// Register bus
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Permissions and core control
	input wire logic        perm_secure_invasive,
	input wire logic        perm_nonsecure_invasive,
	input wire logic        perm_secure_noninvasive,
	input wire logic        perm_nonsecure_noninvasive,
	input wire logic        debug_state,
	input wire logic        exec_valid,
	input wire logic [31:0] exec_opcode,
	input wire logic        exec_done
);
	logic [3:0] pin_q;
	logic [2:0] stable_cnt;
	wire  [3:0] pins = {secure_invasive_enable, invasive_enable,
		secure_noninvasive_enable, noninvasive_enable};
	wire        settled = (stable_cnt >= 3'h4) && (pins == pin_q);
	wire        acc = psel & penable;
	wire        rd_st = acc & !pwrite & (paddr == 12'h088);
	wire        wr_itr = acc & pwrite & (paddr == 12'h084);
	wire        nsi = perm_nonsecure_invasive;
	wire        nsn = perm_nonsecure_noninvasive;

	// Pin stability age; decode is only judged once the pipe has drained
	always_ff @(posedge clk) begin
		pin_q <= pins;
		if (rst || pins != pin_q)
			stable_cnt <= 3'h0;
		else if (stable_cnt != 3'h7)
			stable_cnt <= stable_cnt + 3'h1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////////////
	chk_sinv_decode: assert property (settled |->
		perm_secure_invasive == (pins[3] & pins[2]))
		else $error("secure invasive permission wrong");
	chk_nsinv_decode: assert property (settled |->
		nsi == pins[2]) else $error("nonsecure invasive permission wrong");
	chk_nsni_decode: assert property (settled |->
		nsn == (pins[2] | pins[0])) else $error("nonsecure trace wrong");
	chk_sni_decode: assert property (settled |->
		perm_secure_noninvasive == ((pins[3] | pins[1]) & (pins[2] | pins[0])))
		else $error("secure trace permission wrong");
	chk_mode_masked: assert property (rd_st && !nsi && !$past(nsi) |->
		prdata[15:14] == 2'h0) else $error("mode field not masked");
	chk_halt_gated: assert property ($rose(debug_state) |->
		$past(nsi)) else $error("halt taken without permission");
	chk_auth_bits: assert property (rd_st && $stable(nsi) && $stable(nsn)
		|-> prdata[17:16] == {nsn, nsi}) else $error("status auth bits wrong");
	chk_unmapped_err: assert property (acc |-> pslverr ==
		!(paddr inside {12'h084, 12'h088, 12'h090, 12'hFB8}))
		else $error("error response wrong");
	chk_exec_hold: assert property (exec_valid && !exec_done |=>
		exec_valid && $stable(exec_opcode)) else $error("opcode dropped");
	chk_itr_launch: assert property (wr_itr && debug_state && !exec_valid
		|=> exec_valid && exec_opcode == $past(pwdata))
		else $error("opcode not issued");
	chk_itr_refused: assert property (wr_itr && !debug_state &&
		!exec_valid |=> !exec_valid) else $error("opcode issued while running");
	chk_ext_halt: assert property ((external_halt_request && nsi)[*4]
		|-> debug_state) else $error("external halt not taken");

	// Main scenarios reached
	cover property ($rose(debug_state));
	cover property (exec_valid && exec_done);
	cover property (acc && pslverr);
endmodule

// ==== dv/core_model.sv ====
// Core model that retires forced opcodes after a chosen stall
`timescale 1ns/1ns

module core_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Opcode handshake
	input  wire logic       exec_valid,
	input  wire logic [3:0] delay,
	output logic            exec_done
);
	logic [3:0] wait_r;

	// One retire pulse per opcode; a long stall keeps the flag low
	always_ff @(posedge clk) begin
		if (rst || exec_done) begin
			exec_done <= 1'b0;
			wait_r    <= 4'h0;
		end else if (exec_valid) begin
			if (wait_r == delay)
				exec_done <= 1'b1;
			else
				wait_r <= wait_r + 4'h1;
		end
	end
endmodule

// ==== dv/tb_debug_auth_gate.sv ====
// Self-checking bench for the debug authentication gate
`timescale 1ns/1ns

module tb_debug_auth_gate;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  au = 4'h0;
	logic        halt_req = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [3:0]  dly = 4'h1;
	logic [31:0] prdata, exec_opcode, rd, op;
	logic [3:0]  perm, p;
	logic        pready, pslverr, err, debug_state, exec_valid, exec_done;
	logic [31:0] exp_q[$], seen_q[$];
	int          failures = 0, n_compared = 0, i, n;
	int          mode_m = 0, entry_m = 0;

	debug_auth_gate u_debug_auth_gate (
		.clk(clk), .rst(rst),
		.secure_invasive_enable(au[3]), .invasive_enable(au[2]),
		.secure_noninvasive_enable(au[1]), .noninvasive_enable(au[0]),
		.external_halt_request(halt_req),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.perm_secure_invasive(perm[3]), .perm_nonsecure_invasive(perm[2]),
		.perm_secure_noninvasive(perm[1]),
		.perm_nonsecure_noninvasive(perm[0]),
		.debug_state(debug_state), .exec_valid(exec_valid),
		.exec_opcode(exec_opcode), .exec_done(exec_done));

	core_model u_core_model (.clk(clk), .rst(rst), .exec_valid(exec_valid),
		.delay(dly), .exec_done(exec_done));

	// 250 MHz clock
	always #2 clk = ~clk;

	// Record every retired opcode for the queue comparison
	always @(posedge clk)
		if (exec_valid === 1'b1 && exec_done === 1'b1)
			seen_q.push_back(exec_opcode);

	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("failures=%0d n_compared=%0d", failures, n_compared);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic give_up;
		failures++;
		tally_and_finish();
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One bus transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) give_up();
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wait_ds(input logic v);
		int k;
		k = 0;
		while (debug_state !== v && k < 50) begin
			@(posedge clk);
			k++;
		end
		if (debug_state !== v) give_up();
	endtask

	// Complete flag polling keeps a stalled core from being overrun
	task automatic poll_done;
		int k;
		k = 0;
		do begin
			apb(1'b0, 12'h088, 32'h0);
			k++;
		end while (rd[24] !== 1'b1 && k < 50);
		if (rd[24] !== 1'b1) give_up();
	endtask

	// Reference decode of the four pins
	function automatic logic [3:0] pm(input logic [3:0] v);
		return {v[3] & v[2], v[2], (v[3] | v[1]) & (v[2] | v[0]), v[2] | v[0]};
	endfunction

	function automatic logic [31:0] st_exp(input int h);
		logic [3:0] q;
		q = pm(au);
		return 32'(h) | 32'(entry_m << 2) | 32'(q[2] ? mode_m << 14 : 0)
			| (32'(q[2]) << 16) | (32'(q[0]) << 17) | 32'h0100_0000;
	endfunction

	// Expected authentication status word; odd bits 1, 3, 5 and 7 read as one
	function automatic logic [31:0] as_exp(input logic [3:0] q);
		return {24'h0, 1'b1, q[1], 1'b1, q[3], 1'b1, q[0], 1'b1, q[2]};
	endfunction

	// Pins change, then status is polled until the new decode shows
	task automatic set_pins(input logic [3:0] v);
		int k;
		au <= v;
		p = pm(v);
		k = 0;
		do begin
			apb(1'b0, 12'hFB8, 32'h0);
			k++;
		end while (rd !== as_exp(p) && k < 50);
		if (rd !== as_exp(p)) give_up();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		n = $urandom(1);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h088, 32'h0);
		chk(rd, st_exp(0));
		chk({31'h0, err}, 32'h0);
		// Every pin combination, then random ones
		for (i = 0; i < 24; i++) begin
			set_pins(i < 16 ? 4'(i) : 4'($urandom));
			chk({28'h0, perm}, {28'h0, p});
			apb(1'b0, 12'hFB8, 32'h0);
			chk(rd, as_exp(p));
			apb(1'b0, 12'h088, 32'h0);
			chk(rd, st_exp(0));
		end
		// Mode field masked while invasive debug is off
		set_pins(4'h0);
		apb(1'b1, 12'h088, 32'h0000_C000);
		apb(1'b0, 12'h088, 32'h0);
		chk(32'(rd[15:14]), 32'h0);
		set_pins(4'h4);
		apb(1'b1, 12'h088, 32'h0000_4000);
		mode_m = 1;
		apb(1'b0, 12'h088, 32'h0);
		chk(rd, st_exp(0));
		set_pins(4'h0);
		apb(1'b0, 12'h088, 32'h0);
		chk(rd, st_exp(0));
		// Halt events dropped without invasive permission
		halt_req <= 1'b1;
		repeat (8) @(posedge clk);
		apb(1'b1, 12'h090, 32'h1);
		repeat (3) @(posedge clk);
		chk({31'h0, debug_state}, 32'h0);
		halt_req <= 1'b0;
		set_pins(4'hF);
		halt_req <= 1'b1;
		wait_ds(1'b1);
		halt_req <= 1'b0;
		entry_m = 4;
		apb(1'b0, 12'h088, 32'h0);
		chk(rd, st_exp(1));
		// Forced opcodes, each followed by a refused overwrite
		for (i = 0; i < 6; i++) begin
			dly <= 4'(1 + $urandom % 7);
			op = $urandom;
			poll_done();
			apb(1'b1, 12'h084, op);
			exp_q.push_back(op);
			#1;
			chk({31'h0, exec_valid}, 32'h1);
			chk(exec_opcode, op);
			apb(1'b1, 12'h084, ~op);
			poll_done();
		end
		chk(32'(seen_q.size()), 32'(exp_q.size()));
		for (i = 0; i < exp_q.size() && i < seen_q.size(); i++)
			chk(seen_q[i], exp_q[i]);
		// Write-only and unmapped places
		apb(1'b0, 12'h084, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h100, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		// Restart, refused opcode while running, then run-control halt
		apb(1'b1, 12'h090, 32'h2);
		wait_ds(1'b0);
		apb(1'b1, 12'h084, 32'h1234_5678);
		repeat (3) @(posedge clk);
		chk({31'h0, exec_valid}, 32'h0);
		apb(1'b1, 12'h090, 32'h1);
		wait_ds(1'b1);
		entry_m = 0;
		apb(1'b0, 12'h088, 32'h0);
		chk(rd, st_exp(1));
		tally_and_finish();
	end
endmodule

bind debug_auth_gate debug_auth_gate_sva u_sva (.*);
